// file: src/pt_defines.svh
// Purpose : Shared constants of the pressure/temperature result readout link
// Assumes : mclk at 200 MHz on both ends
// Notes   : Offsets are 8-bit register pointers on the serial link
//
// Overview of operation
// - Host launches conversions writing 0x01 to 0x01
// - Host waits 20 ms before reading results
// - Five result bytes burst-read from 0x04, pointer advancing
// - Launched device refreshes results on its own
// - Pressure 24-bit two's complement, high byte first
// - Pascal equals count over 2^21 times span
// - Temperature 16-bit, high first, above 32768 negative
// - Calibration bytes at 0x20 and 0x21, burst readable
// - Offset byte: sign bit 7, magnitude bits 6:0
// - Shift byte over ten gives 7, 6 or 5.5
// - Host degrees: (raw minus offset)/2^shift plus 25
// - Read: write pointer, repeated start, read address
`ifndef PT_DEFINES_SVH
`define PT_DEFINES_SVH

// ==========================================================================
// Clock and timing
`define PT_MCLK_NS       5
`define PT_WAIT_US       20000
`define PT_WAIT_CYC      ((`PT_WAIT_US * 1000 + `PT_MCLK_NS - 1) / `PT_MCLK_NS)
`define PT_CONV_US       10000
`define PT_CONV_CYC      ((`PT_CONV_US * 1000) / `PT_MCLK_NS)
`define PT_SCL_QTR_NS    625
`define PT_SCL_QTR_CYC   ((`PT_SCL_QTR_NS + `PT_MCLK_NS - 1) / `PT_MCLK_NS)

// ==========================================================================
// Device register pointers and values
`define PT_SLAVE_ADDR    7'h2a // Arbitrary bus address of our own choosing
`define PT_REG_CTRL      8'h01
`define PT_REG_P_HI      8'h04
`define PT_REG_P_MID     8'h05
`define PT_REG_P_LO      8'h06
`define PT_REG_T_HI      8'h07
`define PT_REG_T_LO      8'h08
`define PT_REG_CAL_OFS   8'h20
`define PT_REG_CAL_SHIFT 8'h21
`define PT_LAUNCH_CODE   8'h01
`define PT_CTRL_RESET    8'h37
`define PT_CAL_OFS_DEF   8'h10
`define PT_CAL_SHIFT_DEF 8'h46

// ==========================================================================
// Conversion arithmetic
`define PT_P_FRAC        21
`define PT_SPAN_KPA      700
`define PT_PA_PER_KPA    1000
`define PT_T_NEG_ABOVE   16'h8000
`define PT_T_BIAS        32'sd25
`define PT_T_FRAC        8
`define PT_SHIFT_7       8'h46
`define PT_SHIFT_6       8'h3c
`define PT_INV_SQRT2     32'sd181

// ==========================================================================
// Host command port map
`define PT_HREG_CMD      4'h0
`define PT_HREG_STAT     4'h1
`define PT_HREG_PRAW     4'h2
`define PT_HREG_TRAW     4'h3
`define PT_HREG_CAL      4'h4
`define PT_HREG_PPA      4'h5
`define PT_HREG_TDEG     4'h6
`define PT_CMD_LAUNCH    0
`define PT_CMD_READ      1
`define PT_CMD_CAL       2

`endif

// file: src/pt_pkg.sv
// Purpose : Types shared by both ends of the readout link
// Assumes : pt_defines.svh included before use
// Notes   : State of each end is one packed struct
`default_nettype none
package pt_pkg;
  // ==========================================================================
  // Device side
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_REG, D_WR, D_RD} pt_dev_st_t;
  typedef struct packed {
    pt_dev_st_t  st;
    logic        scl_q;
    logic        sda_q;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        rd_dir;
    logic        nack;
    logic        sda_oe;
    logic [7:0]  ctrl;
    logic        launched;
    logic [31:0] tick;
    logic [39:0] res;
    logic [39:0] snap;
    logic        conv_done;
  } pt_dev_state_t;

  // ==========================================================================
  // Host side
  typedef enum logic [1:0] {OP_START, OP_WR, OP_RD, OP_STOP} pt_op_t;
  typedef enum logic [1:0] {J_LAUNCH, J_RES, J_CAL} pt_job_t;
  typedef enum logic {H_IDLE, H_RUN} pt_host_st_t;
  typedef struct packed {
    pt_op_t     op;
    logic [7:0] dat;
  } pt_step_t;
  typedef struct packed {
    pt_host_st_t st;
    pt_job_t     job;
    logic [3:0]  step;
    logic [3:0]  bitn;
    logic [1:0]  q;
    logic [15:0] div;
    logic [7:0]  sh;
    logic        scl;
    logic        sda_oe;
    logic        abort;
    logic        err;
    logic [39:0] rx;
    logic [23:0] praw;
    logic [15:0] traw;
    logic [15:0] cal;
    logic        launched;
    logic        ready;
    logic [31:0] wcnt;
    logic [31:0] rdata;
  } pt_host_state_t;
endpackage
`default_nettype wire

// file: src/pt_link_if.sv
// Purpose : Two-wire link between host and sensor device
// Assumes : Host alone drives the clock, no stretching
// Notes   : Data line is open drain with an implied pull-up
`default_nettype none
interface pt_link_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // ==========================================================================
  // Wired-AND of both drivers; released line reads high
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface
`default_nettype wire

// file: src/pt_dev_end.sv
// Purpose : Sensor device end: result registers and two-wire slave
// Assumes : scl and sda synchronous to mclk, scl far slower than mclk
// Notes   : Results refresh every CONV_CYCLES once launched
`include "pt_defines.svh"
`default_nettype none
module pt_dev_end #(
  parameter int unsigned CONV_CYCLES = `PT_CONV_CYC,
  parameter logic [7:0]  CAL_OFS     = `PT_CAL_OFS_DEF,
  parameter logic [7:0]  CAL_SHIFT   = `PT_CAL_SHIFT_DEF,
  parameter logic [6:0]  SLAVE_ADDR  = `PT_SLAVE_ADDR
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  pt_link_if.dev           link,
  input  wire logic [23:0] pres_sample,
  input  wire logic [15:0] temp_sample,
  output logic             launched,
  output logic             conv_done
);
  import pt_pkg::*;

  // ==========================================================================
  // Elaboration checks
  if (CONV_CYCLES < 2) begin : g_bad_conv
    $error("CONV_CYCLES must be at least 2");
  end

  pt_dev_state_t s;
  pt_dev_state_t n;
  logic          rise;
  logic          fall;
  logic          start;
  logic          stop;
  logic [7:0]    nxt_byte;

  // ==========================================================================
  // Read mux over the register pointer
  // Results come from the snapshot, never the live copy
  function automatic logic [7:0] rd_byte(input logic [7:0]  a,
                                         input logic [39:0] snap,
                                         input logic [7:0]  ctrl);
    case (a)
      `PT_REG_CTRL:      rd_byte = ctrl;
      `PT_REG_P_HI:      rd_byte = snap[39:32];
      `PT_REG_P_MID:     rd_byte = snap[31:24];
      `PT_REG_P_LO:      rd_byte = snap[23:16];
      `PT_REG_T_HI:      rd_byte = snap[15:8];
      `PT_REG_T_LO:      rd_byte = snap[7:0];
      `PT_REG_CAL_OFS:   rd_byte = CAL_OFS;
      `PT_REG_CAL_SHIFT: rd_byte = CAL_SHIFT;
      default:           rd_byte = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // Line condition detection
  // Start and stop are sda moves while scl stays high
  always_comb begin
    rise  = link.scl & ~s.scl_q;
    fall  = ~link.scl & s.scl_q;
    start = s.scl_q & link.scl & s.sda_q & ~link.sda;
    stop  = s.scl_q & link.scl & ~s.sda_q & link.sda;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    n           = s;
    n.conv_done = 1'b0;
    n.scl_q     = link.scl;
    n.sda_q     = link.sda;
    nxt_byte    = rd_byte(s.ptr + 8'h01, s.snap, s.ctrl);

    // Free-running conversion once launched
    if (s.launched) begin
      if (s.tick == CONV_CYCLES - 1) begin
        n.tick      = 32'h0;
        n.res       = {pres_sample, temp_sample};
        n.conv_done = 1'b1;
      end else begin
        n.tick = s.tick + 32'h1;
      end
    end

    // Start wins over everything, also as a repeated start
    if (start) begin
      n.st     = D_ADDR;
      n.cnt    = 4'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st     = D_IDLE;
      n.sda_oe = 1'b0;
    end else if (s.st != D_IDLE) begin
      // Rising scl: sample incoming bits or the master's acknowledge
      if (rise) begin
        if (s.cnt < 4'h8 && s.st != D_RD) begin
          n.sh = {s.sh[6:0], link.sda};
        end
        if (s.cnt == 4'h8 && s.st == D_RD) begin
          n.nack = link.sda;
        end
        n.cnt = s.cnt + 4'h1;
      end

      // Falling scl: change the data line only while scl is low
      if (fall) begin
        if (s.cnt == 4'h8) begin
          case (s.st)
            D_ADDR: begin
              if (s.sh[7:1] == SLAVE_ADDR) begin
                n.sda_oe = 1'b1;
                n.rd_dir = s.sh[0];
                if (s.sh[0]) begin
                  n.snap = s.res;
                end
              end else begin
                n.st = D_IDLE;
              end
            end
            D_REG: begin
              n.ptr    = s.sh;
              n.sda_oe = 1'b1;
            end
            D_WR: begin
              if (s.ptr == `PT_REG_CTRL) begin
                n.ctrl = s.sh;
                if (s.sh == `PT_LAUNCH_CODE) begin
                  n.launched = 1'b1;
                end
              end
              n.ptr    = s.ptr + 8'h01;
              n.sda_oe = 1'b1;
            end
            D_RD: begin
              n.sda_oe = 1'b0;                     // Let master answer
            end
            default: begin
              n.sda_oe = 1'b0;
            end
          endcase
        end else if (s.cnt == 4'h9) begin
          n.cnt    = 4'h0;
          n.sda_oe = 1'b0;
          case (s.st)
            D_ADDR: begin
              if (s.rd_dir) begin
                n.st     = D_RD;
                n.sh     = rd_byte(s.ptr, s.snap, s.ctrl);
                n.sda_oe = ~n.sh[7];
              end else begin
                n.st = D_REG;
              end
            end
            D_REG: begin
              n.st = D_WR;
            end
            D_RD: begin
              if (s.nack) begin
                n.st = D_IDLE;
              end else begin
                n.ptr    = s.ptr + 8'h01;
                n.sh     = nxt_byte;
                n.sda_oe = ~nxt_byte[7];
              end
            end
            default: begin
              n.st = s.st;
            end
          endcase
        end else if (s.st == D_RD) begin
          // Shift out the next bit, most significant first
          n.sh     = {s.sh[6:0], 1'b0};
          n.sda_oe = ~s.sh[6];
        end
      end
    end
  end

  // ==========================================================================
  // State register
  // Power-on reset only; launch stays until the next reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      s       <= '0;
      s.ctrl  <= `PT_CTRL_RESET;
      // Line copies start at the idle level, so no false edge follows reset
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // Outputs
  // Open drain: the output value is always low, enable pulls
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = s.sda_oe;
  assign launched        = s.launched;
  assign conv_done       = s.conv_done;
endmodule
`default_nettype wire

// file: src/pt_host_end.sv
// Purpose : Host end: launches, waits, reads results and calibration
// Assumes : Software port strobes are one cycle, never together
// Notes   : Commands written while busy are dropped
//
// Local design decision: the plain strobed port.
`include "pt_defines.svh"
`default_nettype none
module pt_host_end #(
  parameter int unsigned WAIT_CYCLES = `PT_WAIT_CYC,
  parameter int unsigned QTR_CYCLES  = `PT_SCL_QTR_CYC,
  parameter int unsigned SPAN_KPA    = `PT_SPAN_KPA,
  parameter logic [6:0]  SLAVE_ADDR  = `PT_SLAVE_ADDR
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  pt_link_if.host          link,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);
  import pt_pkg::*;

  // ==========================================================================
  // Elaboration checks
  if (QTR_CYCLES < 1 || QTR_CYCLES > 65535) begin : g_bad_qtr
    $error("QTR_CYCLES must be 1 to 65535");
  end
  if (WAIT_CYCLES < 1) begin : g_bad_wait
    $error("WAIT_CYCLES must be at least 1");
  end

  pt_host_state_t s;
  pt_host_state_t n;
  pt_step_t       cur;
  pt_op_t         op;
  logic           tick;

  // ==========================================================================
  // Link program of each job
  function automatic pt_step_t op_of(input pt_job_t j, input logic [3:0] k);
    pt_step_t   r;
    logic [3:0] last;
    r    = '{op: OP_STOP, dat: 8'h00};
    last = (j == J_RES) ? 4'd9 : 4'd6;
    case (k)
      4'd0: r.op = OP_START;
      4'd1: r = '{op: OP_WR, dat: {SLAVE_ADDR, 1'b0}};
      4'd2: begin
        r.op  = OP_WR;
        r.dat = (j == J_LAUNCH) ? `PT_REG_CTRL :
                (j == J_RES) ? `PT_REG_P_HI : `PT_REG_CAL_OFS;
      end
      4'd3: begin
        r.op  = (j == J_LAUNCH) ? OP_WR : OP_START;
        r.dat = `PT_LAUNCH_CODE;
      end
      4'd4: if (j != J_LAUNCH) r = '{op: OP_WR, dat: {SLAVE_ADDR, 1'b1}};
      default: if (j != J_LAUNCH && k <= last) begin
        r.op  = OP_RD;
        r.dat = {7'h00, k == last};                 // Last byte gets no ack
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Signed count times span, over 2^21, in pascal
  function automatic logic signed [31:0] to_pa(input logic [23:0] raw);
    logic signed [47:0] p;
    p = 48'(signed'(raw)) * $signed(48'(SPAN_KPA * `PT_PA_PER_KPA));
    return 32'(p >>> `PT_P_FRAC);
  endfunction

  // Temperature in 1/256 degree; 5.5 uses 181/256 for 2^-0.5
  function automatic logic signed [31:0] to_temp(input logic [15:0] raw,
                                                 input logic [15:0] cal);
    logic signed [31:0] ofs;
    logic signed [31:0] d;
    logic signed [31:0] t;
    ofs = $signed({17'h0, cal[14:8], 8'h00});
    if (cal[15]) ofs = -ofs;
    d = (raw > `PT_T_NEG_ABOVE) ? 32'(signed'(raw)) : $signed({16'h0, raw});
    d = d - ofs;
    case (cal[7:0])
      `PT_SHIFT_7: t = (d <<< `PT_T_FRAC) >>> 7;
      `PT_SHIFT_6: t = (d <<< `PT_T_FRAC) >>> 6;
      default:     t = (d * `PT_INV_SQRT2) >>> 5;
    endcase
    return t + (`PT_T_BIAS <<< `PT_T_FRAC);
  endfunction

  // ==========================================================================
  // Next state
  always_comb begin
    n     = s;
    tick  = 1'b0;
    cur   = op_of(s.job, s.step);
    op    = s.abort ? OP_STOP : cur.op;
    // Read data stand one cycle only
    n.rdata = 32'h0;
    if (rd) begin
      case (addr)
        `PT_HREG_STAT: n.rdata = {28'h0, s.launched, s.err, s.ready, s.st == H_RUN};
        `PT_HREG_PRAW: n.rdata = {8'h00, s.praw};
        `PT_HREG_TRAW: n.rdata = {16'h0, s.traw};
        `PT_HREG_CAL:  n.rdata = {16'h0, s.cal};
        `PT_HREG_PPA:  n.rdata = to_pa(s.praw);
        `PT_HREG_TDEG: n.rdata = to_temp(s.traw, s.cal);
        default:       n.rdata = 32'h0;
      endcase
    end

    // Settling wait after launch
    if (s.launched && !s.ready) begin
      if (s.wcnt == 32'(WAIT_CYCLES - 1)) n.ready = 1'b1;
      else n.wcnt = s.wcnt + 32'h1;
    end

    // Command decode; result read refused until settled
    if (wr && addr == `PT_HREG_CMD && s.st == H_IDLE &&
        (wdata[`PT_CMD_LAUNCH] || (wdata[`PT_CMD_READ] && s.ready) ||
         wdata[`PT_CMD_CAL])) begin
      n.st    = H_RUN;
      n.job   = wdata[`PT_CMD_LAUNCH] ? J_LAUNCH :
                (wdata[`PT_CMD_READ] && s.ready) ? J_RES : J_CAL;
      n.step  = 4'h0;
      n.bitn  = 4'h0;
      n.q     = 2'h0;
      n.div   = 16'h0;
      n.abort = 1'b0;
      n.err   = 1'b0;
    end

    // Quarter-bit timer
    if (s.st == H_RUN) begin
      if (s.div == 16'(QTR_CYCLES - 1)) begin
        n.div = 16'h0;
        tick  = 1'b1;
      end else begin
        n.div = s.div + 16'h1;
      end
    end

    // Bit engine: set data, raise scl, sample, lower scl
    if (tick) begin
      n.q = s.q + 2'h1;
      case (s.q)
        2'd0: case (op)
          OP_START: n.sda_oe = 1'b0;
          OP_STOP:  n.sda_oe = 1'b1;
          OP_WR:    n.sda_oe = (s.bitn < 4'h8) & ~cur.dat[3'(4'h7 - s.bitn)];
          default:  n.sda_oe = (s.bitn == 4'h8) & ~cur.dat[0];
        endcase
        2'd1: n.scl = 1'b1;
        2'd2: begin
          if (op == OP_START) n.sda_oe = 1'b1;
          else if (op == OP_STOP) n.sda_oe = 1'b0;
          else if (s.bitn < 4'h8) n.sh = {s.sh[6:0], link.sda};
          else if (op == OP_WR && link.sda) n.err = 1'b1;
        end
        default: begin
          if (op == OP_STOP) begin
            n.st = H_IDLE;
            if (!s.err) begin
              case (s.job)
                J_LAUNCH: begin
                  n.launched = 1'b1;
                  n.ready    = 1'b0;
                  n.wcnt     = 32'h0;
                end
                J_RES: begin
                  n.praw = s.rx[39:16];
                  n.traw = s.rx[15:0];
                end
                default: n.cal = s.rx[15:0];
              endcase
            end
          end else begin
            n.scl = 1'b0;
            if (op == OP_START || s.bitn == 4'h8) begin
              n.bitn  = 4'h0;
              n.step  = s.step + 4'h1;
              n.abort = s.err;                                     // Nack ends job
              if (op == OP_RD) n.rx = {s.rx[31:0], s.sh};
            end else begin
              n.bitn = s.bitn + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // State register; idle line has scl high and sda released
  always_ff @(posedge mclk) begin
    if (rst) begin
      s     <= '0;
      s.scl <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.scl         = s.scl;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = s.sda_oe;
  assign rdata            = s.rdata;
endmodule
`default_nettype wire

// file: verif/pt_link_checker.sv
// Purpose : Wire-level checks on the two-wire readout link
// Assumes : Both ends are design code on one mclk
// Notes   : Scl low time is tied to QTR_CYCLES of the host
`default_nettype none
module pt_link_checker #(
  parameter int unsigned QTR_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lo_q;
  logic [15:0] lo_d;

  // ==========================================================================
  // Helper
  // Cycles of scl low; a counter avoids a long repetition in a property
  always_comb begin
    lo_d = scl ? 16'h0 : lo_q + 16'h1;
  end
  always_ff @(posedge mclk) begin
    lo_q <= rst ? 16'h0 : lo_d;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Assertions
  // Reset itself is the cause here, so this one is never disabled
  AST_RST_IDLE: assert property (disable iff (1'b0)
    rst |=> scl && !host_sda_oe && !dev_sda_oe) else $error("link not idle after reset");
  // Open drain: both ends only ever pull low
  AST_HOST_OD: assert property (!host_sda_o && !dev_sda_o)
    else $error("an end drives sda high");
  // Only the host moves sda with scl high, as a start or a stop
  AST_SDA_HOST: assert property ($changed(sda) && scl && $past(scl)
    |-> $changed(host_sda_oe)) else $error("sda moved with scl high, not by the host");
  // Device data must stay put while scl is high
  AST_DEV_HOLD: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device sda moved with scl high");
  AST_DEV_LATE: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device sda moved too soon after scl fall");
  AST_START: assert property ($rose(host_sda_oe) && scl |-> ##[1:8] !scl)
    else $error("start not followed by scl low");
  AST_STOP: assert property ($fell(host_sda_oe) && scl |-> scl [*8])
    else $error("scl dropped right after stop");
  AST_SCL_LOW: assert property ($rose(scl) |-> lo_q == 16'(2 * QTR_CYCLES))
    else $error("scl low time wrong");

  // ==========================================================================
  // Coverage
  cover property ($rose(host_sda_oe) && scl);
  cover property ($fell(host_sda_oe) && scl);
  cover property (dev_sda_oe && !sda && scl);
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Purpose : Host register port driven end to end against the device end
// Assumes : Shortened counts: wait 200, conversion 50, quarter 4 cycles
// Notes   : Device offset byte 8'h90 (minus 4096), shift byte for six
`include "pt_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OFS_VAL = -4096; // Decoded offset byte 8'h90
  localparam int T_MUL   = 4;     // 256 over 2^6 for shift six
  logic        mclk       = 1'b0;
  logic        rst        = 1'b1;
  logic [3:0]  addr       = 4'h0;
  logic [31:0] wdata      = 32'h0;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [23:0] pres       = 24'h0;
  logic [15:0] temp       = 16'h0;
  logic [31:0] rdata;
  logic        launched;
  logic        conv_done;
  logic [31:0] got;
  logic [39:0] tab [3]    = '{40'h812345_8000, 40'h7fffff_8001, 40'h800000_7fff};
  int          fail_count = 0;
  int          n_tests    = 0;

  always #2.5 mclk = ~mclk;

  pt_link_if u_pt_link_if ();
  pt_host_end #(.WAIT_CYCLES(200), .QTR_CYCLES(4)) u_pt_host_end (
    .mclk(mclk), .rst(rst), .link(u_pt_link_if), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  pt_dev_end #(.CONV_CYCLES(50), .CAL_OFS(8'h90), .CAL_SHIFT(`PT_SHIFT_6)) u_pt_dev_end (
    .mclk(mclk), .rst(rst), .link(u_pt_link_if), .pres_sample(pres),
    .temp_sample(temp), .launched(launched), .conv_done(conv_done));
  pt_link_checker #(.QTR_CYCLES(4)) u_pt_link_checker (
    .mclk(mclk), .rst(rst), .scl(u_pt_link_if.scl), .sda(u_pt_link_if.sda),
    .host_sda_o(u_pt_link_if.host_sda_o), .host_sda_oe(u_pt_link_if.host_sda_oe),
    .dev_sda_o(u_pt_link_if.dev_sda_o), .dev_sda_oe(u_pt_link_if.dev_sda_oe));

  // ==========================================================================
  // Reporting
  task automatic conclude();
    $display("TB: %0d checks, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic give_up(string what);
    fail_count++;
    $display("Error %s expected done seen timeout", what);
    conclude();
  endtask
  task automatic check(string name, logic [31:0] exp, logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ==========================================================================
  // Register port: strobes one cycle, read data the cycle after
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  // Polls busy; a job of a few bytes needs well under the bound
  task automatic wait_idle();
    for (int i = 0; i < 2000; i++) begin
      rd_reg(`PT_HREG_STAT);
      if (got[0] === 1'b0)
        return;
    end
    give_up("job");
  endtask
  task automatic wait_conv();
    for (int i = 0; i < 100; i++) begin
      @(posedge mclk);
      #1;
      if (conv_done === 1'b1)
        return;
    end
    give_up("conv_done");
  endtask

  // ==========================================================================
  // Expected values from the scaling rules
  function automatic logic [31:0] exp_pa(logic [23:0] p);
    longint s;
    s = longint'($signed(p)) * `PT_SPAN_KPA * `PT_PA_PER_KPA;
    return 32'(s >>> `PT_P_FRAC);
  endfunction
  function automatic logic [31:0] exp_t(logic [15:0] t);
    int v;
    v = (t > 16'h8000) ? int'(t) - 65536 : int'(t);
    return 32'((v - OFS_VAL) * T_MUL + 25 * 256);
  endfunction

  // ==========================================================================
  // Main sequence
  initial begin
    int  k;
    time t0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // Result read before launch is refused; unmapped index reads zero
    wr_reg(`PT_HREG_CMD, 32'h2);
    rd_reg(`PT_HREG_STAT);
    check("stat before launch", 32'h0, got);
    rd_reg(4'hf);
    check("unmapped", 32'h0, got);
    // Launch, then ready only after the wait
    wr_reg(`PT_HREG_CMD, 32'h1);
    t0 = $time;
    rd_reg(`PT_HREG_STAT);
    check("stat at launch", 32'h1, got);
    wait_idle();
    check("stat launched", 32'h8, got & 32'he);
    check("dev launched", 32'h1, {31'h0, launched});
    for (k = 0; k < 300 && got[1] !== 1'b1; k++)
      rd_reg(`PT_HREG_STAT);
    if (k == 300)
      give_up("ready");
    check("ready late enough", 32'h1, {31'h0, ($time - t0) >= 1000});
    // Calibration pair in one transfer
    wr_reg(`PT_HREG_CMD, 32'h4);
    wait_idle();
    rd_reg(`PT_HREG_CAL);
    check("calibration", {16'h0, 8'h90, `PT_SHIFT_6}, got);
    // Fresh samples show up with no further launch
    for (k = 0; k < 3; k++) begin
      {pres, temp} <= tab[k];
      wait_conv();
      wait_conv();
      wr_reg(`PT_HREG_CMD, 32'h2);
      wait_idle();
      rd_reg(`PT_HREG_PRAW);
      check("pressure raw", {8'h0, tab[k][39:16]}, got);
      rd_reg(`PT_HREG_TRAW);
      check("temperature raw", {16'h0, tab[k][15:0]}, got);
      rd_reg(`PT_HREG_PPA);
      check("pressure pa", exp_pa(tab[k][39:16]), got);
      rd_reg(`PT_HREG_TDEG);
      check("temperature", exp_t(tab[k][15:0]), got);
    end
    // Writes to result words are ignored; a launch while busy is dropped
    wr_reg(`PT_HREG_PRAW, 32'hffffffff);
    wr_reg(`PT_HREG_CMD, 32'h4);
    wr_reg(`PT_HREG_CMD, 32'h1);
    wait_idle();
    check("ready kept", 32'h2, got & 32'h6);
    rd_reg(`PT_HREG_PRAW);
    check("raw kept", {8'h0, tab[2][39:16]}, got);
    // Reset in mid job returns the link and flags to idle
    wr_reg(`PT_HREG_CMD, 32'h4);
    repeat (50) @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(`PT_HREG_STAT);
    check("stat after reset", 32'h0, got);
    check("launch cleared", 32'h0, {31'h0, launched});
    check("idle wire", 32'h3, {30'h0, u_pt_link_if.scl, u_pt_link_if.sda});
    conclude();
  end
endmodule
`default_nettype wire
